// ===== shared/board_regs_pkg.sv
package board_regs_pkg;

  // ------------------------------------------------------------
  // register offsets in the decoded i/o window
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_PRODUCT_CODE_LED = 8'h00;
  localparam logic [7:0] OFF_BUILD_STATUS = 8'h01;
  localparam logic [7:0] OFF_BOOT_SELECT_CONTROL = 8'h02;
  localparam logic [7:0] OFF_TIMER_IRQ_MASK = 8'h03;
  localparam logic [7:0] OFF_TIMER_IRQ_STATUS = 8'h04;
  localparam logic [7:0] OFF_CHAN1_DATA = 8'h05; // channels follow at consecutive offsets

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_USER_LED_ON = 7;
  localparam int BIT_WIDE_TEMP_GRADE = 2;
  localparam int BIT_CUSTOM = 1;
  localparam int BIT_BETA = 0;
  localparam int BIT_BOOT_STRAP_STATE = 7;
  localparam int BIT_BOOT_STRAP_OVERRIDE = 6;
  localparam int BIT_BOOT_IMAGE_SOFT_SELECT = 5;
  localparam int BIT_YELLOW_LED_FORCE = 4;
  localparam int BIT_UNRELEASED_IMAGE = 3;
  localparam int BIT_SPARE_JUMPER_STATE = 1;
  localparam int BIT_TIMER_IRQ_GLOBAL_ENABLE = 7;
  localparam int LSB_TIMER_IRQ_LINE_SELECT = 4;

  // ------------------------------------------------------------
  // reset values and sizes
  // ------------------------------------------------------------
  localparam logic RST_CTRL_BIT = 1'b0;
  localparam logic [2:0] RST_IRQ_LINE_SELECT = 3'h0;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  localparam int NUM_CHAN = 3;
  localparam int CHAN_WIDTH = 16;

  // pin index in the synchroniser bank
  localparam int PIN_BOOT = 0;
  localparam int PIN_TEMP = 1;
  localparam int PIN_SPARE = 2;
  localparam int PIN_ACT = 3;
  localparam int PIN_TICK = 4;
  localparam int NUM_PINS = 5;

  // one decoded i/o cycle from the host front end
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } io_req_s;

  // board pins, all asynchronous to clk_sys_i
  typedef struct packed {
    logic tick;          // counter input clock
    logic storage_activity;
    logic spare_jumper_state;
    logic wide_temp_grade;
    logic boot_strap_state;
  } pins_s;

endpackage

// ===== verilog/board_status_control_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// - product register bit 7 is a writable user led, reset off.
// - product register bits 6..0 read a fixed product code, writes ignored.
// - build status bits 7..3 read the logic revision number.
// - build status bit 2 reads the temperature grade strap.
// - build status bit 1 reads the custom build constant.
// - build status bit 0 reads the beta build constant.
// - boot control bit 7 reads the boot image jumper.
// - boot control bit 6 makes image select follow software instead of jumper.
// - boot control bit 5 is the software image select, reset zero.
// - boot control bit 4 forces the yellow led on.
// - boot control bit 3 reads the unreleased image constant.
// - boot control bit 1 reads the spare jumper.
// - reserved bits ignore writes and read zero.
// - three independent 16-bit interval counter channels.
// - timer mask bit 7 is the global timer interrupt enable.
// - timer mask bits 6..4 select the serial irq line, reset 000.
// - timer mask bits 2..0 enable each channel's interrupt.
// - channel flag sets when the output rises at terminal count reload, not on a count load; cleared by writing one.
module board_status_control_regs #(
  parameter logic [6:0] PRODUCT_CODE = 7'h2A, // arbitrary value
  parameter logic [4:0] LOGIC_REVISION = 5'h01,
  parameter logic CUSTOM_BUILD = 1'b0,
  parameter logic BETA_BUILD = 1'b0,
  parameter logic UNRELEASED_IMAGE = 1'b0
) (
  input wire logic clk_sys_i, // 40 mhz system clock
  input wire logic srst_i, // synchronous reset, high
  input wire board_regs_pkg::io_req_s io_req_i, // decoded i/o cycle
  input wire board_regs_pkg::pins_s pins_i, // asynchronous board pins
  output logic [7:0] rd_data_o, // read data
  output logic rd_valid_o, // read data strobe
  output logic user_led_on_o, // paddleboard led
  output logic boot_image_sel_o, // 1 primary image
  output logic yellow_led_o, // yellow led drive
  output logic [2:0] chan_out_o, // counter channel outputs
  output logic [7:0] serirq_lines_o // one bit per select code
);
  import board_regs_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [NUM_PINS-1:0] sync1;
    logic [NUM_PINS-1:0] sync2;
    logic tick_d;
    logic user_led_on;
    logic boot_strap_override;
    logic boot_image_soft_select;
    logic yellow_led_force;
    logic timer_irq_global_enable;
    logic [2:0] timer_irq_line_select;
    logic [NUM_CHAN-1:0] chan_irq_mask;
    logic [NUM_CHAN-1:0] chan_flag;
    logic [NUM_CHAN-1:0][CHAN_WIDTH-1:0] reload;
    logic [NUM_CHAN-1:0][CHAN_WIDTH-1:0] count;
    logic [NUM_CHAN-1:0] hi_next;
    logic [NUM_CHAN-1:0] run;
    logic [NUM_CHAN-1:0] chan_out;
    logic [7:0] rd_data;
    logic rd_valid;
    logic boot_sel;
    logic yellow_led;
    logic [7:0] serirq;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  // address match, shared by read and write decode
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic tick;
    logic [CHAN_WIDTH-1:0] cnt_next;
    logic [7:0] rdv;
    logic [7:0] chan_off;
    st_nxt = st_r;
    tick = 1'b0;
    cnt_next = '0;
    rdv = RD_UNMAPPED;
    chan_off = OFF_CHAN1_DATA;
    // pins pass two flops; only the second stage feeds logic
    st_nxt.sync1 = pins_i;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.tick_d = st_r.sync2[PIN_TICK];
    tick = st_r.sync2[PIN_TICK] & ~st_r.tick_d;
    st_nxt.rd_valid = io_req_i.rd;

    // register writes; read-only and reserved bits have no storage
    if (io_req_i.wr) begin
      if (hit(io_req_i.addr, OFF_PRODUCT_CODE_LED)) begin
        st_nxt.user_led_on = io_req_i.wdata[BIT_USER_LED_ON];
      end else if (hit(io_req_i.addr, OFF_BOOT_SELECT_CONTROL)) begin
        st_nxt.boot_strap_override = io_req_i.wdata[BIT_BOOT_STRAP_OVERRIDE];
        st_nxt.boot_image_soft_select = io_req_i.wdata[BIT_BOOT_IMAGE_SOFT_SELECT];
        st_nxt.yellow_led_force = io_req_i.wdata[BIT_YELLOW_LED_FORCE];
      end else if (hit(io_req_i.addr, OFF_TIMER_IRQ_MASK)) begin
        st_nxt.timer_irq_global_enable = io_req_i.wdata[BIT_TIMER_IRQ_GLOBAL_ENABLE];
        st_nxt.timer_irq_line_select = io_req_i.wdata[LSB_TIMER_IRQ_LINE_SELECT +: 3];
        st_nxt.chan_irq_mask = io_req_i.wdata[NUM_CHAN-1:0];
      end else if (hit(io_req_i.addr, OFF_TIMER_IRQ_STATUS)) begin
        st_nxt.chan_flag = st_r.chan_flag & ~io_req_i.wdata[NUM_CHAN-1:0];
      end
    end

    // counter channels, lsb then msb load like the classic timer
    for (int c = 0; c < NUM_CHAN; c++) begin
      chan_off = OFF_CHAN1_DATA + 8'(c);
      if (io_req_i.wr && hit(io_req_i.addr, chan_off)) begin
        st_nxt.hi_next[c] = ~st_r.hi_next[c];
        if (!st_r.hi_next[c]) begin
          st_nxt.reload[c][7:0] = io_req_i.wdata;
        end else begin
          st_nxt.reload[c][15:8] = io_req_i.wdata;
          st_nxt.count[c] = {io_req_i.wdata, st_r.reload[c][7:0]};
          st_nxt.run[c] = 1'b1;
          st_nxt.chan_out[c] = 1'b1;
        end
      end else if (st_r.run[c] && tick) begin
        // rate generator: low for the tick at count one, reload after
        cnt_next = (st_r.count[c] == 16'h0001) ? st_r.reload[c] : st_r.count[c] - 16'h0001;
        st_nxt.count[c] = cnt_next;
        st_nxt.chan_out[c] = (cnt_next != 16'h0001);
        // flag on rising output; setting wins over a clear
        if (!st_r.chan_out[c] && st_nxt.chan_out[c]) begin
          st_nxt.chan_flag[c] = 1'b1;
        end
      end
    end

    // register reads
    if (hit(io_req_i.addr, OFF_PRODUCT_CODE_LED)) begin
      rdv = {st_r.user_led_on, PRODUCT_CODE};
    end else if (hit(io_req_i.addr, OFF_BUILD_STATUS)) begin
      rdv = {LOGIC_REVISION, st_r.sync2[PIN_TEMP], CUSTOM_BUILD, BETA_BUILD};
    end else if (hit(io_req_i.addr, OFF_BOOT_SELECT_CONTROL)) begin
      // bits 2 and 0 read zero
      rdv = {st_r.sync2[PIN_BOOT], st_r.boot_strap_override, st_r.boot_image_soft_select,
             st_r.yellow_led_force, UNRELEASED_IMAGE, 1'b0, st_r.sync2[PIN_SPARE], 1'b0};
    end else if (hit(io_req_i.addr, OFF_TIMER_IRQ_MASK)) begin
      rdv = {st_r.timer_irq_global_enable, st_r.timer_irq_line_select, 1'b0,
             st_r.chan_irq_mask};
    end else if (hit(io_req_i.addr, OFF_TIMER_IRQ_STATUS)) begin
      rdv = {5'h00, st_r.chan_flag};
    end else if (io_req_i.addr >= OFF_CHAN1_DATA
                 && io_req_i.addr < OFF_CHAN1_DATA + 8'(NUM_CHAN)) begin
      // limitation: only the low count byte, no latch command
      rdv = st_r.count[2'(io_req_i.addr - OFF_CHAN1_DATA)][7:0];
    end
    if (io_req_i.rd) begin
      st_nxt.rd_data = rdv;
    end

    // image select follows jumper unless overridden
    st_nxt.boot_sel = st_r.boot_strap_override ? st_r.boot_image_soft_select
                                               : st_r.sync2[PIN_BOOT];
    st_nxt.yellow_led = st_r.yellow_led_force | st_r.sync2[PIN_ACT];
    // one line driven, picked by the select code
    st_nxt.serirq = '0;
    if (st_r.timer_irq_global_enable && |(st_r.chan_irq_mask & st_r.chan_flag)) begin
      st_nxt.serirq[st_r.timer_irq_line_select] = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_r <= '0;
      st_r.timer_irq_line_select <= RST_IRQ_LINE_SELECT;
      st_r.user_led_on <= RST_CTRL_BIT;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops
  assign rd_data_o = st_r.rd_data;
  assign rd_valid_o = st_r.rd_valid;
  assign user_led_on_o = st_r.user_led_on;
  assign boot_image_sel_o = st_r.boot_sel;
  assign yellow_led_o = st_r.yellow_led;
  assign chan_out_o = st_r.chan_out;
  assign serirq_lines_o = st_r.serirq;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  chk_led_write: assert property (
    io_req_i.wr && io_req_i.addr == OFF_PRODUCT_CODE_LED
    |=> user_led_on_o == $past(io_req_i.wdata[BIT_USER_LED_ON]))
    else $error("user led did not take written value");

  chk_product_read: assert property (
    io_req_i.rd && io_req_i.addr == OFF_PRODUCT_CODE_LED
    |=> rd_valid_o && rd_data_o[6:0] == PRODUCT_CODE)
    else $error("product code read wrong");

  chk_build_read: assert property (
    io_req_i.rd && io_req_i.addr == OFF_BUILD_STATUS
    |=> rd_data_o == {LOGIC_REVISION, $past(st_r.sync2[PIN_TEMP]), CUSTOM_BUILD, BETA_BUILD})
    else $error("build status read wrong");

  chk_boot_mux: assert property (
    !$past(srst_i) |-> boot_image_sel_o == ($past(st_r.boot_strap_override)
      ? $past(st_r.boot_image_soft_select) : $past(st_r.sync2[PIN_BOOT])))
    else $error("boot image select source wrong");

  chk_yellow_force: assert property (
    st_r.yellow_led_force ##1 st_r.yellow_led_force |-> yellow_led_o)
    else $error("yellow led not forced on");

  chk_reserved_zero: assert property (
    io_req_i.rd && io_req_i.addr == OFF_BOOT_SELECT_CONTROL
    |=> rd_data_o[2] == 1'b0 && rd_data_o[0] == 1'b0)
    else $error("reserved bit read nonzero");

  // a count load also raises the output, but only terminal count may set the flag
  chk_flag_rise: assert property (
    !st_r.chan_out[0]
    ##1 (st_r.chan_out[0] && !$past(io_req_i.wr && io_req_i.addr == OFF_CHAN1_DATA))
    |-> st_r.chan_flag[0])
    else $error("flag missed rising output");

  chk_flag_clear: assert property (
    io_req_i.wr && io_req_i.addr == OFF_TIMER_IRQ_STATUS && io_req_i.wdata[0]
    && !(!st_r.chan_out[0] && st_nxt.chan_out[0]) |=> !st_r.chan_flag[0])
    else $error("flag not cleared by write one");

  chk_temp_read: assert property (
    io_req_i.rd && io_req_i.addr == OFF_BUILD_STATUS
    |=> rd_data_o[BIT_WIDE_TEMP_GRADE] == $past(st_r.sync2[PIN_TEMP]))
    else $error("temperature strap read wrong");

  chk_jumper_read: assert property (
    io_req_i.rd && io_req_i.addr == OFF_BOOT_SELECT_CONTROL
    |=> rd_data_o[BIT_SPARE_JUMPER_STATE] == $past(st_r.sync2[PIN_SPARE])
        && rd_data_o[BIT_BOOT_STRAP_STATE] == $past(st_r.sync2[PIN_BOOT]))
    else $error("jumper status read wrong");

  chk_soft_write: assert property (
    io_req_i.wr && io_req_i.addr == OFF_BOOT_SELECT_CONTROL
    |=> st_r.boot_image_soft_select == $past(io_req_i.wdata[BIT_BOOT_IMAGE_SOFT_SELECT])
        && st_r.boot_strap_override == $past(io_req_i.wdata[BIT_BOOT_STRAP_OVERRIDE]))
    else $error("boot control write lost");

  chk_force_write: assert property (
    io_req_i.wr && io_req_i.addr == OFF_BOOT_SELECT_CONTROL
    |=> st_r.yellow_led_force == $past(io_req_i.wdata[BIT_YELLOW_LED_FORCE]))
    else $error("led force write lost");

  chk_enable_write: assert property (
    io_req_i.wr && io_req_i.addr == OFF_TIMER_IRQ_MASK
    |=> st_r.timer_irq_global_enable == $past(io_req_i.wdata[BIT_TIMER_IRQ_GLOBAL_ENABLE])
        && st_r.chan_irq_mask == $past(io_req_i.wdata[NUM_CHAN-1:0]))
    else $error("timer enable or mask write lost");

  chk_line_write: assert property (
    io_req_i.wr && io_req_i.addr == OFF_TIMER_IRQ_MASK
    |=> st_r.timer_irq_line_select == $past(io_req_i.wdata[LSB_TIMER_IRQ_LINE_SELECT +: 3]))
    else $error("irq line select write lost");

  chk_unmapped_read: assert property (
    io_req_i.rd && io_req_i.addr >= OFF_CHAN1_DATA + 8'(NUM_CHAN)
    |=> rd_data_o == RD_UNMAPPED)
    else $error("unmapped offset read nonzero");

  chk_count_load: assert property (
    io_req_i.wr && io_req_i.addr == OFF_CHAN1_DATA && st_r.hi_next[0]
    |=> st_r.run[0] && chan_out_o[0]
        && st_r.count[0] == {$past(io_req_i.wdata), $past(st_r.reload[0][7:0])})
    else $error("channel count not loaded");

  chk_mask_reset: assert property (
    $past(srst_i) |-> st_r.chan_irq_mask == '0 && !st_r.timer_irq_global_enable)
    else $error("mask bits not zero after reset");

  chk_irq_line: assert property (
    !$past(srst_i) |-> serirq_lines_o == (($past(st_r.timer_irq_global_enable)
      && |($past(st_r.chan_irq_mask) & $past(st_r.chan_flag)))
      ? 8'(8'h01 << $past(st_r.timer_irq_line_select)) : 8'h00))
    else $error("serial irq line wrong");

endmodule

// ===== tb/host_io_model.sv
`timescale 1ns/1ps
module host_io_model
  import board_regs_pkg::*;
(
  input wire logic clk_sys_i, // system clock
  input wire logic [7:0] rd_data_i, // device read data
  input wire logic rd_valid_i, // device read strobe
  output board_regs_pkg::io_req_s io_req_o // decoded i/o cycle
);
  initial io_req_o = '0;

  // one-cycle write strobe; released lines show inverted data, not the old value
  task automatic io_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    io_req_o = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk_sys_i);
    io_req_o = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask

  // data taken while the one-cycle valid strobe stands, before the release
  task automatic io_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    io_req_o = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge clk_sys_i);
    d = rd_valid_i ? rd_data_i : 8'hXX;
    io_req_o = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hFF};
  endtask
endmodule

// ===== tb/board_status_control_regs_tb_top.sv
`timescale 1ns/1ps
module board_status_control_regs_tb_top;
  import board_regs_pkg::*;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
  } row_s;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  pins_s pins = 5'h03; // primary jumper, extended grade
  io_req_s io_req;
  logic [7:0] rd_data, irq_lines, rd;
  logic rd_valid, user_led, boot_sel, yellow_led;
  logic [2:0] chan_out;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  // write a value, read back what must stay
  row_s rows [8] = '{
    '{OFF_PRODUCT_CODE_LED, 8'hFF, 8'hD5},
    '{OFF_PRODUCT_CODE_LED, 8'h00, 8'h55},
    '{OFF_BUILD_STATUS, 8'hFF, 8'h9E},
    '{OFF_BOOT_SELECT_CONTROL, 8'hFF, 8'hF8},
    '{OFF_BOOT_SELECT_CONTROL, 8'h00, 8'h88},
    '{OFF_TIMER_IRQ_MASK, 8'hFF, 8'hF7},
    '{OFF_TIMER_IRQ_MASK, 8'h00, 8'h00},
    '{8'h08, 8'hFF, 8'h00}
  };

  always #12.5 clk_sys_i = ~clk_sys_i;

  host_io_model i_host_io_model (
    .clk_sys_i(clk_sys_i),
    .rd_data_i(rd_data),
    .rd_valid_i(rd_valid),
    .io_req_o(io_req)
  );

  board_status_control_regs #(
    .PRODUCT_CODE(7'h55),
    .LOGIC_REVISION(5'h13),
    .CUSTOM_BUILD(1'b1),
    .BETA_BUILD(1'b0),
    .UNRELEASED_IMAGE(1'b1)
  ) i_board_status_control_regs (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .io_req_i(io_req),
    .pins_i(pins),
    .rd_data_o(rd_data),
    .rd_valid_o(rd_valid),
    .user_led_on_o(user_led),
    .boot_image_sel_o(boot_sel),
    .yellow_led_o(yellow_led),
    .chan_out_o(chan_out),
    .serirq_lines_o(irq_lines)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // writes, then lets synced and derived outputs settle
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    i_host_io_model.io_write(a, d);
    repeat (4) @(negedge clk_sys_i);
  endtask

  // tick is synchronised, so each level is held a few cycles
  task automatic pulse_tick();
    pins.tick = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    pins.tick = 1'b0;
    repeat (4) @(negedge clk_sys_i);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // hang guard, far above the few hundred cycles needed
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(negedge clk_sys_i);
    srst_i = 1'b0;
    foreach (rows[i]) begin
      i_host_io_model.io_write(rows[i].addr, rows[i].wdata);
      i_host_io_model.io_read(rows[i].addr, rd);
      check(rd, rows[i].rdata);
    end
    // second reset with every writable control register bit set
    put(OFF_PRODUCT_CODE_LED, 8'hFF);
    put(OFF_BOOT_SELECT_CONTROL, 8'hFF);
    put(OFF_TIMER_IRQ_MASK, 8'hFF);
    srst_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    check({5'h00, user_led, boot_sel, yellow_led}, 8'h00);
    srst_i = 1'b0;
    i_host_io_model.io_read(OFF_PRODUCT_CODE_LED, rd);
    check(rd, 8'h55);
    i_host_io_model.io_read(OFF_BOOT_SELECT_CONTROL, rd);
    check(rd, 8'h88);
    i_host_io_model.io_read(OFF_TIMER_IRQ_MASK, rd);
    check(rd, 8'h00);
    put(OFF_PRODUCT_CODE_LED, 8'h80);
    check({7'h00, user_led}, 8'h01);
    put(OFF_BOOT_SELECT_CONTROL, 8'h40);
    check({7'h00, boot_sel}, 8'h00);
    put(OFF_BOOT_SELECT_CONTROL, 8'h60);
    check({7'h00, boot_sel}, 8'h01);
    pins.boot_strap_state = 1'b0;
    put(OFF_BOOT_SELECT_CONTROL, 8'h10);
    check({7'h00, boot_sel}, 8'h00);
    check({7'h00, yellow_led}, 8'h01);
    pins.storage_activity = 1'b1;
    put(OFF_BOOT_SELECT_CONTROL, 8'h00);
    check({7'h00, yellow_led}, 8'h01);
    pins.storage_activity = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    check({7'h00, yellow_led}, 8'h00);
    pins.spare_jumper_state = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    i_host_io_model.io_read(OFF_BOOT_SELECT_CONTROL, rd);
    check(rd, 8'h0A);
    // channel 1 reload of 2, lsb then msb
    put(OFF_CHAN1_DATA, 8'h02);
    put(OFF_CHAN1_DATA, 8'h00);
    check({5'h00, chan_out}, 8'h01);
    repeat (3) pulse_tick();
    check({5'h00, chan_out}, 8'h00);
    i_host_io_model.io_read(OFF_TIMER_IRQ_STATUS, rd);
    check(rd, 8'h01);
    for (int s = 0; s < 8; s++) begin
      put(OFF_TIMER_IRQ_MASK, {1'b1, s[2:0], 4'h1});
      check(irq_lines, 8'h01 << s);
    end
    put(OFF_TIMER_IRQ_MASK, 8'h71);
    check(irq_lines, 8'h00);
    put(OFF_TIMER_IRQ_MASK, 8'hF6);
    check(irq_lines, 8'h00);
    put(OFF_TIMER_IRQ_MASK, 8'hF1);
    put(OFF_TIMER_IRQ_STATUS, 8'h01);
    check(irq_lines, 8'h00);
    i_host_io_model.io_read(OFF_TIMER_IRQ_STATUS, rd);
    check(rd, 8'h00);
    wrap_up();
  end
endmodule
